// ### core/vsc_pkg.sv
// vsc_pkg: constants, register map and types of the setpoint conditioning chain
// assumes a 32-bit apb slave; samples are signed 16-bit, full scale +/-0x7FFF
package vsc_pkg;
    localparam logic signed [18:0] FS = 19'sh07FFF;
    // excursion beyond the valid span that counts as a broken signal
    localparam logic signed [18:0] OOR_MARGIN = 19'sh00CCD;
    localparam logic [8:0] DB_STEP = 9'h148;
    localparam logic [10:0] GAIN_MAX = 11'h400;
    localparam int GAIN_FRAC = 8;
    localparam int LIN_MAX = 21;
    localparam logic [4:0] LIN_MIN = 5'h03;
    localparam logic [4:0] LIN_TOP = 5'h15;
    localparam logic [5:0] DIV_STEPS = 6'h22;

    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_DBAND = 12'h004;
    localparam logic [11:0] REG_GPOS = 12'h008;
    localparam logic [11:0] REG_GNEG = 12'h00C;
    localparam logic [11:0] REG_OFS = 12'h010;
    localparam logic [11:0] REG_IMAX = 12'h014;
    localparam logic [11:0] REG_LCNT = 12'h018;
    localparam logic [11:0] REG_LIDX = 12'h01C;
    localparam logic [11:0] REG_LPT = 12'h020;
    localparam logic [11:0] REG_STAT = 12'h024;
    localparam logic [11:0] REG_OUT = 12'h028;

    localparam logic [7:0] CTRL_RST = 8'h10;
    localparam logic [10:0] GAIN_RST = 11'h100;
    localparam logic [14:0] IMAX_RST = 15'h7FFF;
    localparam int STAT_LREJ = 2;

    typedef enum logic [2:0] {CT_SYM, CT_UNI, CT_CTR, CT_RAT10, CT_RAT5} vsc_ctype_t;

    typedef struct packed {
        vsc_ctype_t ctype;
        logic two_coil;
        logic lin_act;
        logic dis_out;
        logic rng_inv;
        logic pol_neg;
    } vsc_cfg_t;

    typedef struct packed {
        logic [14:0] ofs;
        logic [10:0] gneg;
        logic [10:0] gpos;
        logic [15:0] thr;
    } vsc_shp_cfg_t;
endpackage

// ### core/vsc_shape.sv
// vsc_shape: deadband, split gain and overlap offset, purely combinational
// assumes input already clamped to +/-full scale
`timescale 1ns/1ps
module vsc_shape import vsc_pkg::*; (
    // sample
    input wire logic signed [15:0] x_i,
    input wire vsc_shp_cfg_t cfg_i,
    // result
    output logic signed [15:0] y_o
);
    logic signed [16:0] mag;
    logic signed [15:0] d;
    logic [10:0] g;
    logic signed [28:0] p;
    logic signed [28:0] s;

    always_comb begin
        mag = x_i[15] ? -17'(x_i) : 17'(x_i);
        d = (mag < $signed({1'b0, cfg_i.thr})) ? 16'sh0000 : x_i;
        g = d[15] ? cfg_i.gneg : cfg_i.gpos;
        p = (29'(d) * $signed({18'h0, g})) >>> GAIN_FRAC;
        if (d > 16'sh0000) begin
            s = p + $signed({14'h0, cfg_i.ofs});
        end else if (d < 16'sh0000) begin
            s = p - $signed({14'h0, cfg_i.ofs});
        end else begin
            s = 29'sh0;
        end
        if (s > 29'(FS)) begin
            y_o = 16'(FS);
        end else if (s < -29'(FS)) begin
            y_o = -16'(FS);
        end else begin
            y_o = 16'(s);
        end
    end
endmodule // vsc_shape

// ### core/vsc_lin.sv
// vsc_lin: linearisation table with search and serial interpolation divider
// assumes points are loaded in ascending index order
`timescale 1ns/1ps
module vsc_lin import vsc_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // table load
    input wire logic we_i,
    input wire logic [4:0] widx_i,
    input wire logic signed [15:0] wx_i,
    input wire logic signed [15:0] wy_i,
    input wire logic [4:0] cnt_i,
    output logic rej_o,
    // conversion
    input wire logic start_i,
    input wire logic signed [15:0] x_i,
    output logic busy_o,
    output logic done_o,
    output logic signed [15:0] y_o
);
    typedef enum {L_IDLE, L_SRCH, L_DIV} vsc_lst_t;
    vsc_lst_t st_reg;
    logic signed [15:0] tx [LIN_MAX];
    logic signed [15:0] ty [LIN_MAX];
    logic [4:0] idx_reg;
    logic signed [15:0] xin_reg;
    logic signed [15:0] base_reg;
    logic [17:0] rem_reg;
    logic [33:0] quo_reg;
    logic [16:0] den_reg;
    logic [5:0] cnt_reg;
    logic [17:0] tmp;
    logic ok;
    logic div_end_reg;

    // strictly rising x and non-falling y against the previous point
    always_comb begin
        ok = (widx_i < LIN_TOP) && ((widx_i == 5'h00) ||
             (wx_i > tx[widx_i - 5'h01] && wy_i >= ty[widx_i - 5'h01]));
        rej_o = we_i & ~ok;
        tmp = {rem_reg[16:0], quo_reg[33]};
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < LIN_MAX; i++) begin
                tx[i] <= 16'sh0000;
                ty[i] <= 16'sh0000;
            end
        end else if (we_i && ok) begin
            tx[widx_i] <= wx_i;
            ty[widx_i] <= wy_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg <= L_IDLE;
            idx_reg <= 5'h00;
            xin_reg <= 16'sh0000;
            base_reg <= 16'sh0000;
            rem_reg <= 18'h0;
            quo_reg <= 34'h0;
            den_reg <= 17'h0;
            cnt_reg <= 6'h00;
            done_o <= 1'b0;
            y_o <= 16'sh0000;
        end else begin
            done_o <= 1'b0;
            unique case (st_reg)
                L_IDLE: begin
                    if (start_i) begin
                        xin_reg <= x_i;
                        idx_reg <= 5'h00;
                        st_reg <= L_SRCH;
                    end
                end
                L_SRCH: begin
                    if (xin_reg <= tx[0]) begin
                        y_o <= ty[0];
                        done_o <= 1'b1;
                        st_reg <= L_IDLE;
                    end else if (idx_reg == cnt_i - 5'h01) begin
                        y_o <= ty[idx_reg];
                        done_o <= 1'b1;
                        st_reg <= L_IDLE;
                    end else if (xin_reg <= tx[idx_reg + 5'h01]) begin
                        quo_reg <= 34'(17'(xin_reg - tx[idx_reg]) * 17'(ty[idx_reg + 5'h01] - ty[idx_reg]));
                        den_reg <= 17'(tx[idx_reg + 5'h01] - tx[idx_reg]);
                        base_reg <= ty[idx_reg];
                        rem_reg <= 18'h0;
                        cnt_reg <= DIV_STEPS;
                        st_reg <= L_DIV;
                    end else begin
                        idx_reg <= idx_reg + 5'h01;
                    end
                end
                L_DIV: begin
                    if (tmp >= {1'b0, den_reg}) begin
                        rem_reg <= tmp - {1'b0, den_reg};
                        quo_reg <= {quo_reg[32:0], 1'b1};
                    end else begin
                        rem_reg <= tmp;
                        quo_reg <= {quo_reg[32:0], 1'b0};
                    end
                    cnt_reg <= cnt_reg - 6'h01;
                    if (cnt_reg == 6'h01) begin
                        st_reg <= L_IDLE;
                    end
                end
            endcase
            if (div_end_reg) begin
                y_o <= base_reg + 16'(quo_reg);
                done_o <= 1'b1;
            end
        end
    end

    // quotient is complete the cycle after the last step
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_end_reg <= 1'b0;
        end else begin
            div_end_reg <= (st_reg == L_DIV) && (cnt_reg == 6'h01);
        end
    end

    assign busy_o = (st_reg != L_IDLE) | div_end_reg;
endmodule // vsc_lin

// ### core/vsc_top.sv
// vsc_top: setpoint conditioning chain of a proportional valve, apb register slave
// assumes digitised command on cmd_raw_i, one sample per cmd_valid_i pulse
// Operation
// - negative polarity negates the raw command before anything else
// - two-coil range inversion swaps the sign, so the other coil drives
// - single-coil range inversion maps command c to full scale minus c
// - disable-output option cuts both coils on an out-of-range command
// - coils return automatically with the first valid command
// - no-action option keeps driving, output clamped at maximum current
// - for type CT_SYM and two-coil CT_UNI, polarity and inversion cancel when both set; centred and ratiometric types keep an offset
// - a type not offered or mismatching sets an error and blocks drive
// - out-of-range raises an error and holds the last valid command
// - ratiometric inputs centre on half supply, span 10 V or 5 V
// - commands below the deadband threshold give zero
// - commands above the threshold pass at unity
// - separate positive and negative gains, above zero and up to four
// - offset added toward the active edge, stepping over overlap
// - linearisation points must rise monotonically, others rejected
// - linearisation uses three to twenty-one points
// - linearisation applies only while its enable is set
// - offered command types depend on one or two coils
// - offset-centred types read zero input as a nonzero command
`timescale 1ns/1ps
module vsc_top import vsc_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // command input
    input wire logic signed [15:0] cmd_raw_i,
    input wire logic cmd_valid_i,
    input wire logic signed [15:0] ucc_half_i,
    // conditioned setpoint
    output logic signed [15:0] setp_o,
    output logic setp_valid_o,
    output logic coil_a_en_o,
    output logic coil_b_en_o,
    output logic range_err_o,
    output logic cfg_err_o
);
    vsc_cfg_t cfg_reg;
    logic [6:0] dband_reg;
    logic [10:0] gpos_reg;
    logic [10:0] gneg_reg;
    logic [14:0] ofs_reg;
    logic [14:0] imax_reg;
    logic [4:0] lcnt_reg;
    logic [4:0] lidx_reg;
    logic lrej_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic out_en_reg;
    logic range_err_reg;
    logic cfg_err_reg;
    logic signed [15:0] held_reg;
    logic signed [15:0] a_val_reg;
    logic a_vld_reg;
    logic signed [15:0] b_val_reg;
    logic b_vld_reg;
    logic signed [15:0] setp_reg;
    logic setp_vld_reg;
    logic coil_a_reg;
    logic coil_b_reg;

    logic acc;
    logic wr;
    logic hit;
    logic [31:0] rd_data;
    logic signed [18:0] r_p;
    logic signed [18:0] u_x;
    logic signed [18:0] n;
    logic signed [18:0] lo;
    logic signed [15:0] n_c;
    logic oor;
    logic cfg_err_c;
    vsc_shp_cfg_t shp_cfg;
    logic signed [15:0] shp_y;
    logic lin_we;
    logic lin_rej;
    logic lin_busy;
    logic lin_done;
    logic signed [15:0] lin_y;
    logic fin_vld;
    logic signed [15:0] fin;
    logic signed [15:0] fin_c;
    logic signed [15:0] imax_s;

    assign wr = psel_i & penable_i & pwrite_i & pready_reg;
    assign acc = cmd_valid_i & ~(a_vld_reg | b_vld_reg | lin_busy);
    assign lin_we = wr && paddr_i == REG_LPT;

    // register read mux and decode
    always_comb begin
        hit = 1'b1;
        rd_data = 32'h0;
        unique case (paddr_i)
            REG_CTRL: rd_data = {24'h0, cfg_reg};
            REG_DBAND: rd_data = {25'h0, dband_reg};
            REG_GPOS: rd_data = {21'h0, gpos_reg};
            REG_GNEG: rd_data = {21'h0, gneg_reg};
            REG_OFS: rd_data = {17'h0, ofs_reg};
            REG_IMAX: rd_data = {17'h0, imax_reg};
            REG_LCNT: rd_data = {27'h0, lcnt_reg};
            REG_LIDX: rd_data = {27'h0, lidx_reg};
            REG_LPT: rd_data = 32'h0;
            REG_STAT: rd_data = {27'h0, lin_busy, out_en_reg, lrej_reg, cfg_err_reg, range_err_reg};
            REG_OUT: rd_data = {16'h0, setp_reg};
            default: hit = 1'b0;
        endcase
    end

    // one wait state so read data leaves a flop
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end else begin
            pready_reg <= psel_i & penable_i & ~pready_reg;
            pslverr_reg <= psel_i & penable_i & ~pready_reg & ~hit;
            if (psel_i & penable_i & ~pready_reg) begin
                prdata_reg <= (pwrite_i || !hit) ? 32'h0 : rd_data;
            end
        end
    end

    // configuration; out-of-limit gain or count writes are ignored
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_reg <= vsc_cfg_t'(CTRL_RST);
            dband_reg <= 7'h00;
            gpos_reg <= GAIN_RST;
            gneg_reg <= GAIN_RST;
            ofs_reg <= 15'h0000;
            imax_reg <= IMAX_RST;
            lcnt_reg <= LIN_MIN;
        end else if (wr) begin
            if (paddr_i == REG_CTRL) begin
                cfg_reg <= vsc_cfg_t'(pwdata_i[7:0]);
            end
            if (paddr_i == REG_DBAND && pwdata_i[6:0] <= 7'h64) begin
                dband_reg <= pwdata_i[6:0];
            end
            if (paddr_i == REG_GPOS && pwdata_i[10:0] != 11'h000 && pwdata_i[10:0] <= GAIN_MAX) begin
                gpos_reg <= pwdata_i[10:0];
            end
            if (paddr_i == REG_GNEG && pwdata_i[10:0] != 11'h000 && pwdata_i[10:0] <= GAIN_MAX) begin
                gneg_reg <= pwdata_i[10:0];
            end
            if (paddr_i == REG_OFS) begin
                ofs_reg <= pwdata_i[14:0];
            end
            if (paddr_i == REG_IMAX) begin
                imax_reg <= pwdata_i[14:0];
            end
            if (paddr_i == REG_LCNT && pwdata_i[4:0] >= LIN_MIN && pwdata_i[4:0] <= LIN_TOP) begin
                lcnt_reg <= pwdata_i[4:0];
            end
        end
    end

    // table pointer auto-advances; reject flag is sticky, set beats clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lidx_reg <= 5'h00;
            lrej_reg <= 1'b0;
        end else begin
            if (wr && paddr_i == REG_LIDX) begin
                lidx_reg <= pwdata_i[4:0];
            end else if (lin_we && !lin_rej) begin
                lidx_reg <= lidx_reg + 5'h01;
            end
            if (lin_rej) begin
                lrej_reg <= 1'b1;
            end else if (wr && paddr_i == REG_STAT && pwdata_i[STAT_LREJ]) begin
                lrej_reg <= 1'b0;
            end
        end
    end

    // sign, type decode, inversion and range check
    always_comb begin
        r_p = cfg_reg.pol_neg ? -19'(cmd_raw_i) : 19'(cmd_raw_i);
        u_x = 19'(ucc_half_i);
        lo = -FS;
        cfg_err_c = 1'b0;
        unique case (cfg_reg.ctype)
            CT_SYM: n = r_p;
            CT_UNI: begin
                n = r_p;
                lo = 19'sh0;
            end
            CT_CTR: n = (r_p <<< 1) - FS;
            CT_RAT10: n = r_p - u_x;
            CT_RAT5: n = (r_p - u_x) <<< 1;
            default: begin
                n = 19'sh0;
                cfg_err_c = 1'b1;
            end
        endcase
        if (!cfg_reg.two_coil && cfg_reg.ctype != CT_UNI) begin
            cfg_err_c = 1'b1;
        end
        if (cfg_reg.rng_inv) begin
            n = cfg_reg.two_coil ? -n : FS - n;
        end
        oor = (n > FS + OOR_MARGIN) || (n < lo - OOR_MARGIN);
        if (n > FS) begin
            n_c = 16'(FS);
        end else if (n < lo) begin
            n_c = 16'(lo);
        end else begin
            n_c = 16'(n);
        end
    end

    // stage a: accept sample, handle broken command
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            a_vld_reg <= 1'b0;
            a_val_reg <= 16'sh0000;
            held_reg <= 16'sh0000;
            out_en_reg <= 1'b0;
            range_err_reg <= 1'b0;
            cfg_err_reg <= 1'b0;
        end else begin
            a_vld_reg <= acc;
            cfg_err_reg <= cfg_err_c;
            if (acc) begin
                if (cfg_err_c) begin
                    out_en_reg <= 1'b0;
                    a_val_reg <= 16'sh0000;
                end else if (oor) begin
                    range_err_reg <= 1'b1;
                    out_en_reg <= ~cfg_reg.dis_out;
                    a_val_reg <= held_reg;
                end else begin
                    range_err_reg <= 1'b0;
                    out_en_reg <= 1'b1;
                    held_reg <= n_c;
                    a_val_reg <= n_c;
                end
            end
        end
    end

    assign shp_cfg = '{ofs: ofs_reg, gneg: gneg_reg, gpos: gpos_reg, thr: 16'(dband_reg * DB_STEP)};

    vsc_shape u_shape (
        .x_i(a_val_reg),
        .cfg_i(shp_cfg),
        .y_o(shp_y)
    );

    // stage b: shaped value waits for table or bypass
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            b_vld_reg <= 1'b0;
            b_val_reg <= 16'sh0000;
        end else begin
            b_vld_reg <= a_vld_reg;
            b_val_reg <= shp_y;
        end
    end

    vsc_lin u_lin (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(lin_we),
        .widx_i(lidx_reg),
        .wx_i(pwdata_i[15:0]),
        .wy_i(pwdata_i[31:16]),
        .cnt_i(lcnt_reg),
        .rej_o(lin_rej),
        .start_i(b_vld_reg & cfg_reg.lin_act),
        .x_i(b_val_reg),
        .busy_o(lin_busy),
        .done_o(lin_done),
        .y_o(lin_y)
    );

    // final clamp at maximum current, coil steering by sign
    always_comb begin
        fin_vld = (b_vld_reg & ~cfg_reg.lin_act) | lin_done;
        fin = lin_done ? lin_y : b_val_reg;
        imax_s = $signed({1'b0, imax_reg});
        if (fin > imax_s) begin
            fin_c = imax_s;
        end else if (fin < -imax_s) begin
            fin_c = -imax_s;
        end else begin
            fin_c = fin;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            setp_vld_reg <= 1'b0;
            setp_reg <= 16'sh0000;
            coil_a_reg <= 1'b0;
            coil_b_reg <= 1'b0;
        end else begin
            setp_vld_reg <= fin_vld;
            if (fin_vld) begin
                setp_reg <= out_en_reg ? fin_c : 16'sh0000;
                coil_a_reg <= out_en_reg && fin_c > 16'sh0000;
                coil_b_reg <= out_en_reg && cfg_reg.two_coil && fin_c < 16'sh0000;
            end
        end
    end

    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign setp_o = setp_reg;
    assign setp_valid_o = setp_vld_reg;
    assign coil_a_en_o = coil_a_reg;
    assign coil_b_en_o = coil_b_reg;
    assign range_err_o = range_err_reg;
    assign cfg_err_o = cfg_err_reg;

    AST_DIS_CUT: assert property (@(posedge clk_i) disable iff (rst_i)
        acc && !cfg_err_c && oor && cfg_reg.dis_out |-> ##[3:70] (setp_valid_o && !coil_a_en_o && !coil_b_en_o))
        else $error("coils driven after broken command");
    AST_RESTORE: assert property (@(posedge clk_i) disable iff (rst_i)
        acc && !cfg_err_c && !oor |=> out_en_reg && !range_err_o)
        else $error("drive not restored on valid command");
    AST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        acc && !cfg_err_c && oor && !cfg_reg.dis_out |=> a_val_reg == $past(held_reg) && range_err_o && out_en_reg)
        else $error("last valid command not held");
    AST_CLAMP: assert property (@(posedge clk_i) disable iff (rst_i)
        setp_valid_o |-> setp_o <= $signed({1'b0, imax_reg}) && setp_o >= -$signed({1'b0, imax_reg}))
        else $error("setpoint beyond maximum current");
    AST_DBAND: assert property (@(posedge clk_i) disable iff (rst_i)
        a_vld_reg && (a_val_reg[15] ? -17'(a_val_reg) : 17'(a_val_reg)) < $signed({1'b0, shp_cfg.thr})
        |=> b_val_reg == 16'sh0000)
        else $error("deadband passed a small command");
    AST_BYPASS: assert property (@(posedge clk_i) disable iff (rst_i)
        b_vld_reg && !cfg_reg.lin_act |=> setp_valid_o && !lin_busy)
        else $error("bypass did not pass through");
    AST_CFG: assert property (@(posedge clk_i) disable iff (rst_i)
        acc && cfg_err_c |=> !out_en_reg && cfg_err_o)
        else $error("bad configuration still drives");
    AST_LCNT: assert property (@(posedge clk_i) disable iff (rst_i)
        lcnt_reg >= LIN_MIN && lcnt_reg <= LIN_TOP)
        else $error("point count out of range");
    AST_LREJ: assert property (@(posedge clk_i) disable iff (rst_i)
        lin_rej |=> lrej_reg && $stable(lidx_reg))
        else $error("non-monotonic point not rejected");
    AST_PIPE: assert property (@(posedge clk_i) disable iff (rst_i)
        acc |-> ##[3:70] setp_valid_o)
        else $error("sample lost in chain");
endmodule // vsc_top

// ### sim/vsc_cmd_src.sv
// vsc_cmd_src: command source model, one sample in flight
// assumes send is called just after a rising clock edge
`timescale 1ns/1ps
module vsc_cmd_src (
    // clock and handshake
    input wire logic clk_i,
    input wire logic setp_valid_i,
    // command
    output logic signed [15:0] cmd_raw_o,
    output logic cmd_valid_o
);
    initial begin
        cmd_raw_o = 16'h0000;
        cmd_valid_o = 1'b0;
    end
    task automatic send(input logic [15:0] v, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        cmd_raw_o <= v;
        cmd_valid_o <= 1'b1;
        @(posedge clk_i);
        // junk between samples, never a stale value
        cmd_raw_o <= ~v;
        cmd_valid_o <= 1'b0;
        while (!ok && n < 100) begin
            @(posedge clk_i);
            n++;
            ok = (setp_valid_i === 1'b1);
        end
    endtask
endmodule // vsc_cmd_src

// ### sim/vsc_top_tb.sv
// vsc_top_tb: directed checks of the setpoint chain
// assumes vsc_cmd_src as command source, ratiometric level driven by the bench
`timescale 1ns/1ps
module vsc_top_tb import vsc_pkg::*;;
    logic clk_i = 1'b0, rst_i = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic ok, err, pready, perr, sval, ca, cb, rerr, cerr, cval;
    logic [11:0] pad = 12'h000;
    logic [31:0] pwd = 32'h0, prd, r;
    logic signed [15:0] setp, craw, ucc = 16'sh0000;
    int fails = 0, n_compared = 0, cyc = 0;
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    vsc_top dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(pad), .pwdata_i(pwd), .prdata_o(prd), .pready_o(pready), .pslverr_o(perr),
        .cmd_raw_i(craw), .cmd_valid_i(cval), .ucc_half_i(ucc), .setp_o(setp),
        .setp_valid_o(sval), .coil_a_en_o(ca), .coil_b_en_o(cb), .range_err_o(rerr), .cfg_err_o(cerr));
    vsc_cmd_src src (.clk_i(clk_i), .setp_valid_i(sval), .cmd_raw_o(craw), .cmd_valid_o(cval));
    task automatic close_out;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("Error at %0t: got %h, expected %h", $time, s, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        pad <= a;
        pwd <= d;
        @(posedge clk_i);
        pen <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        r = prd;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic smp(input logic [15:0] v, input logic [15:0] e, input logic [1:0] c);
        src.send(v, ok);
        chk({31'h0, ok}, 32'h1);
        chk({16'h0000, setp}, {16'h0000, e});
        chk({30'h0, ca, cb}, {30'h0, c});
    endtask
    task automatic t_regs;
        apb(1'b0, REG_CTRL, 32'h0);
        chk(r, {24'h0, CTRL_RST});
        apb(1'b1, REG_GPOS, 32'h0);
        apb(1'b0, REG_GPOS, 32'h0);
        chk(r, {21'h0, GAIN_RST});
        apb(1'b0, 12'hFFC, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, REG_LCNT, 32'h2);
        apb(1'b1, REG_LCNT, 32'h16);
        apb(1'b0, REG_LCNT, 32'h0);
        chk(r, 32'h3);
        apb(1'b1, REG_LPT, 32'h01000100);
        apb(1'b1, REG_LPT, 32'h00800200);
        apb(1'b0, REG_STAT, 32'h0);
        chk({31'h0, r[STAT_LREJ]}, 32'h1);
        $display("test regs done");
    endtask
    task automatic t_sign;
        smp(16'h1000, 16'h1000, 2'b10);
        smp(16'hF000, 16'hF000, 2'b01);
        apb(1'b1, REG_CTRL, 32'h11);
        smp(16'h1000, 16'hF000, 2'b01);
        apb(1'b1, REG_CTRL, 32'h12);
        smp(16'h1000, 16'hF000, 2'b01);
        apb(1'b1, REG_CTRL, 32'h13);
        smp(16'h1000, 16'h1000, 2'b10);
        apb(1'b1, REG_CTRL, 32'h22);
        smp(16'h1000, 16'h6FFF, 2'b10);
        apb(1'b1, REG_CTRL, 32'h00);
        smp(16'h1000, 16'h0000, 2'b00);
        chk({31'h0, cerr}, 32'h1);
        $display("test sign done");
    endtask
    task automatic t_range;
        apb(1'b1, REG_CTRL, 32'h24);
        smp(16'h1000, 16'h1000, 2'b10);
        smp(16'hE000, 16'h0000, 2'b00);
        chk({31'h0, rerr}, 32'h1);
        smp(16'h1000, 16'h1000, 2'b10);
        apb(1'b1, REG_CTRL, 32'h20);
        smp(16'hE000, 16'h1000, 2'b10);
        $display("test range done");
    endtask
    task automatic t_shape;
        apb(1'b1, REG_CTRL, 32'h10);
        apb(1'b1, REG_DBAND, 32'h5);
        smp(16'h0600, 16'h0000, 2'b00);
        smp(16'h0700, 16'h0700, 2'b10);
        apb(1'b1, REG_GNEG, 32'h200);
        smp(16'hF800, 16'hF000, 2'b01);
        apb(1'b1, REG_OFS, 32'h100);
        smp(16'h0700, 16'h0800, 2'b10);
        smp(16'hF800, 16'hEF00, 2'b01);
        $display("test shape done");
    endtask
    task automatic t_lin;
        ucc <= 16'sh1000;
        apb(1'b1, REG_CTRL, 32'h70);
        smp(16'h3000, 16'h2100, 2'b10);
        apb(1'b1, REG_CTRL, 32'h90);
        smp(16'h1800, 16'h1100, 2'b10);
        apb(1'b1, REG_CTRL, 32'h50);
        smp(16'h0000, 16'h8001, 2'b01);
        apb(1'b1, REG_LPT, 32'h02000400);
        apb(1'b1, REG_LPT, 32'h08001000);
        apb(1'b1, REG_CTRL, 32'h18);
        smp(16'h0700, 16'h0400, 2'b10);
        smp(16'h0000, 16'h0100, 2'b10);
        apb(1'b1, REG_CTRL, 32'h10);
        apb(1'b1, REG_IMAX, 32'h300);
        smp(16'h0700, 16'h0300, 2'b10);
        $display("test lin done");
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_sign();
        t_range();
        t_shape();
        t_lin();
        close_out();
    end
    // far above the few hundred cycles the tests need
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
    end
endmodule // vsc_top_tb
